// ==== design/cpu_core_pkg.sv ====
`include "cpu_core_regs.svh"
package cpu_core_pkg;

  typedef enum logic [4:0] {
    op_none, op_add, op_adc, op_sub, op_sbc, op_and, op_or, op_xor,
    op_load, op_shl, op_shr, op_load_x, op_load_h, op_load_indexed,
    op_branch_ge, op_set_mask, stack_low_reload_op, mask_clear_op,
    interrupt_return_op, software_trap_op, push_high_index_op,
    pull_high_index_op, op_wait, op_stop
  } op_t;

  typedef enum logic [2:0] {
    st_run, st_push, st_fetch, st_pull, st_load, st_wait, st_stop,
    st_recover
  } state_t;

  typedef logic [`CNT_W-1:0] cnt_t;

  typedef struct packed {
    logic [15:0] addr;
    logic [7:0]  wdata;
    logic        write;
    logic        read;
  } mem_req_t;

  typedef struct packed {
    logic [3:0] addr;
    logic [7:0] wdata;
    logic       write;
    logic       read;
  } reg_req_t;

  typedef struct packed {
    state_t                 st;
    logic [2:0]             step;
    logic [1:0]             ph;
    cnt_t                   cnt;
    logic                   entry;
    logic                   quiet;
    logic [15:0]            vec;
    logic [7:0]             acc;
    logic [7:0]             xh;
    logic [7:0]             xl;
    logic [15:0]            sp;
    logic [15:0]            pc;
    logic [7:0]             cc;
    logic                   in_brk;
    logic                   rdy;
    logic                   done;
    logic                   illegal;
    logic                   stopped;
    mem_req_t               mem;
    logic [7:0]             rdata;
    logic [`IRQ_LINES-1:0]  irq_m;
    logic [`IRQ_LINES-1:0]  irq_s;
  } core_t;

endpackage

// ==== design/cpu_core_regs.svh ====
`ifndef CPU_CORE_REGS_SVH
`define CPU_CORE_REGS_SVH

`define RST_STACK    16'h00ff
`define STACK_LOW_FF 8'hff
`define VEC_RESET    16'hfffe
`define VEC_TRAP     16'hfffc
`define VEC_TRAP_MON 16'hfefc
`define VEC_IRQ_TOP  16'hfffa
`define IRQ_LINES    4

`define CC_V 7
`define CC_H 4
`define CC_I 3
`define CC_N 2
`define CC_Z 1
`define CC_C 0
`define CC_ONES  8'h60
`define CC_RESET 8'h68

`define REC_SHORT 32
`define REC_LONG  4096
`define CNT_W     13

`define RA_ACC    4'h0
`define RA_XH     4'h1
`define RA_XL     4'h2
`define RA_STK_HI 4'h3
`define RA_STK_LO 4'h4
`define RA_PRG_HI 4'h5
`define RA_PRG_LO 4'h6
`define RA_CC     4'h7
`define RA_STATUS 4'h8

`endif

// ==== design/cpu_register_flag_core.sv ====
`timescale 1ns/1ps
`include "cpu_core_regs.svh"
////////////////////////////////////////////////////////////////////////////
////////////////////////////////////////////////////////////////////////////
module cpu_register_flag_core #(
  parameter int LONG_RECOVERY = `REC_LONG // long stop recovery cycles
) (
  input  wire logic                   i_clock,        // 40 mhz
  input  wire logic                   i_reset,        // sync, high
  input  wire logic                   i_clock_en,     // freeze when low
  input  wire logic                   i_op_valid,     // op offered
  input  wire cpu_core_pkg::op_t      i_op,           // op code
  input  wire logic [7:0]             i_operand,      // immediate byte
  input  wire logic [7:0]             i_mem_rdata,    // memory read data
  input  wire logic [`IRQ_LINES-1:0]  i_irq,          // request pins
  input  wire logic                   i_break,        // break request
  input  wire logic                   i_break_en,     // break enabled
  input  wire logic                   i_monitor,      // monitor mode
  input  wire logic                   i_stop_enable,  // stop allowed
  input  wire logic                   i_short_recovery, // short delay
  input  wire cpu_core_pkg::reg_req_t i_reg,          // register port
  output logic                        o_ready,        // op may be taken
  output logic                        o_done,         // op finished
  output logic                        o_illegal,      // illegal op
  output logic                        o_clock_stopped,// wait or stop
  output logic                        o_in_break,     // in break handler
  output cpu_core_pkg::mem_req_t      o_mem,          // memory request
  output logic [7:0]                  o_reg_rdata,    // register read
  output logic [7:0]                  o_accumulator,  // accumulator
  output logic [15:0]                 o_index_pair,   // index pair
  output logic [15:0]                 o_stack_pointer,// stack pointer
  output logic [15:0]                 o_program_counter, // pc
  output logic [7:0]                  o_condition_code_reg // codes
);
  import cpu_core_pkg::*;

  localparam int WW = $clog2(`IRQ_LINES);

  core_t                 q;
  core_t                 d;
  logic [`IRQ_LINES-1:0] irq_pend;
  logic                  brk_pend;
  logic                  entering;
  logic                  take;
  logic                  entry_req;
  logic [WW-1:0]         win;
  logic [7:0]            res;
  logic [7:0]            hx;
  logic [8:0]            sum;
  logic [8:0]            dif;
  logic                  cin;
  logic                  cf;
  logic                  v;
  logic                  alu;
  logic                  hc_exp;
  logic [4:0]            nib;

  ////////////////////////////////////////////////////////////////////////
  // next state
  always_comb
  begin
    d = q;
    d.done = 1'b0;
    d.illegal = 1'b0;
    d.mem.write = 1'b0;
    d.mem.read = 1'b0;
    d.rdata = 8'h00;
    d.irq_m = i_irq;
    d.irq_s = q.irq_m;
    irq_pend = q.irq_s & {`IRQ_LINES{~q.cc[`CC_I]}};
    brk_pend = i_break_en & i_break & ~q.in_brk;
    win = '0;
    for (int k = `IRQ_LINES - 1; k >= 0; k--)
    begin
      if (irq_pend[k])
        win = k[WW-1:0];
    end
    entering = (q.st == st_run) & (brk_pend | (|irq_pend));
    take = (q.st == st_run) & q.rdy & i_op_valid & ~entering;
    entry_req = entering;
    cin = q.cc[`CC_C] & (i_op == op_adc || i_op == op_sbc);
    sum = {1'b0, q.acc} + {1'b0, i_operand} + {8'h00, cin};
    dif = {1'b0, q.acc} - {1'b0, i_operand} - {8'h00, cin};
    nib = {1'b0, q.acc[3:0]} + {1'b0, i_operand[3:0]};
    hc_exp = nib[4];
    res = q.acc;
    hx = 8'h00;
    cf = q.cc[`CC_C];
    v = q.cc[`CC_V];
    alu = 1'b0;

    // register port
    if (i_reg.read)
    begin
      case (i_reg.addr)
        `RA_ACC:    d.rdata = q.acc;
        `RA_XH:     d.rdata = q.xh;
        `RA_XL:     d.rdata = q.xl;
        `RA_STK_HI: d.rdata = q.sp[15:8];
        `RA_STK_LO: d.rdata = q.sp[7:0];
        `RA_PRG_HI: d.rdata = q.pc[15:8];
        `RA_PRG_LO: d.rdata = q.pc[7:0];
        `RA_CC:     d.rdata = q.cc;
        `RA_STATUS: d.rdata = {4'h0, q.in_brk, q.stopped, q.rdy,
                               q.st == st_run};
        default:    d.rdata = 8'h00;
      endcase
    end
    if (i_reg.write && q.st == st_run)
    begin
      case (i_reg.addr)
        `RA_ACC:    d.acc = i_reg.wdata;
        `RA_XH:     d.xh = i_reg.wdata;
        `RA_XL:     d.xl = i_reg.wdata;
        `RA_STK_HI: d.sp[15:8] = i_reg.wdata;
        `RA_STK_LO: d.sp[7:0] = i_reg.wdata;
        `RA_PRG_HI: d.pc[15:8] = i_reg.wdata;
        `RA_PRG_LO: d.pc[7:0] = i_reg.wdata;
        // mask bit kept; ones forced
        `RA_CC:     d.cc = {i_reg.wdata[7], 2'b11, i_reg.wdata[4],
                            q.cc[`CC_I], i_reg.wdata[2:0]};
        default:    d.cc = d.cc;
      endcase
    end

    // shared read sequencing: issue, wait, capture
    if (q.st == st_fetch || q.st == st_pull || q.st == st_load)
    begin
      d.ph = q.ph + 2'h1;
      if (q.ph == 2'h0)
        d.mem.read = 1'b1;
    end

    case (q.st)
      st_run:
      begin
        d.rdy = 1'b1;
        if (take)
        begin
          d.rdy = 1'b0;
          d.done = 1'b1;
          case (i_op)
            op_add, op_adc:
            begin
              res = sum[7:0];
              cf = sum[8];
              v = (q.acc[7] == i_operand[7]) & (res[7] != q.acc[7]);
              hx = q.acc ^ i_operand ^ res;
              d.cc[`CC_H] = hx[4];
              alu = 1'b1;
            end
            op_sub, op_sbc:
            begin
              res = dif[7:0];
              cf = dif[8];
              v = (q.acc[7] != i_operand[7]) & (res[7] != q.acc[7]);
              alu = 1'b1;
            end
            op_and, op_or, op_xor, op_load:
            begin
              case (i_op)
                op_and:  res = q.acc & i_operand;
                op_or:   res = q.acc | i_operand;
                op_xor:  res = q.acc ^ i_operand;
                default: res = i_operand;
              endcase
              v = 1'b0;
              alu = 1'b1;
            end
            op_shl:
            begin
              res = {q.acc[6:0], 1'b0};
              cf = q.acc[7];
              v = res[7] ^ q.acc[7];
              alu = 1'b1;
            end
            op_shr:
            begin
              res = {1'b0, q.acc[7:1]};
              cf = q.acc[0];
              v = q.acc[0];
              alu = 1'b1;
            end
            op_load_x:
              d.xl = i_operand;
            op_load_h:
              d.xh = i_operand;
            op_branch_ge:
            begin
              if (q.cc[`CC_N] == q.cc[`CC_V])
                d.pc = q.pc + {{8{i_operand[7]}}, i_operand};
            end
            op_set_mask:
              d.cc[`CC_I] = 1'b1;
            mask_clear_op:
              d.cc[`CC_I] = 1'b0;
            stack_low_reload_op:
              d.sp[7:0] = `STACK_LOW_FF;
            software_trap_op:
            begin
              d.done = 1'b0;
              d.st = st_push;
              d.entry = 1'b1;
              d.quiet = 1'b0;
              d.step = 3'h0;
              d.vec = i_monitor ? `VEC_TRAP_MON : `VEC_TRAP;
            end
            interrupt_return_op, pull_high_index_op:
            begin
              d.done = 1'b0;
              d.st = st_pull;
              d.entry = (i_op == interrupt_return_op);
              d.step = 3'h0;
              d.ph = 2'h0;
            end
            push_high_index_op:
            begin
              d.done = 1'b0;
              d.st = st_push;
              d.entry = 1'b0;
              d.step = 3'h0;
            end
            op_load_indexed:
            begin
              d.done = 1'b0;
              d.st = st_load;
              d.ph = 2'h0;
            end
            op_wait:
            begin
              d.done = 1'b0;
              d.cc[`CC_I] = 1'b0;
              d.st = st_wait;
              d.stopped = 1'b1;
            end
            op_stop:
            begin
              if (!i_stop_enable)
                d.illegal = 1'b1;
              else
              begin
                d.done = 1'b0;
                d.cc[`CC_I] = 1'b0;
                d.st = st_stop;
                d.stopped = 1'b1;
              end
            end
            default:
              d.done = 1'b1;
          endcase
          if (alu)
          begin
            d.acc = res;
            d.cc[`CC_V] = v;
            d.cc[`CC_N] = res[7];
            d.cc[`CC_Z] = (res == 8'h00);
            d.cc[`CC_C] = cf;
          end
        end
      end
      st_push:
      begin
        d.mem.write = 1'b1;
        d.mem.addr = q.sp;
        d.sp = q.sp - 16'h0001;
        if (!q.entry)
          d.mem.wdata = q.xh;
        else
        begin
          case (q.step)
            3'h0:    d.mem.wdata = q.pc[7:0];
            3'h1:    d.mem.wdata = q.pc[15:8];
            3'h2:    d.mem.wdata = q.xl;
            3'h3:    d.mem.wdata = q.acc;
            default: d.mem.wdata = q.cc;
          endcase
        end
        if (!q.entry)
        begin
          d.st = st_run;
          d.done = 1'b1;
        end
        else if (q.step == 3'h4)
        begin
          d.cc[`CC_I] = 1'b1;
          d.st = st_fetch;
          d.step = 3'h0;
          d.ph = 2'h0;
        end
        else
          d.step = q.step + 3'h1;
      end
      st_fetch:
      begin
        if (q.ph == 2'h0)
          d.mem.addr = q.vec + {13'h0000, q.step};
        if (q.ph == 2'h2)
        begin
          d.ph = 2'h0;
          if (q.step == 3'h0)
          begin
            d.pc[15:8] = i_mem_rdata;
            d.step = 3'h1;
          end
          else
          begin
            d.pc[7:0] = i_mem_rdata;
            d.st = st_run;
            d.done = ~q.quiet;
          end
        end
      end
      st_pull:
      begin
        if (q.ph == 2'h0)
        begin
          d.sp = q.sp + 16'h0001;
          d.mem.addr = q.sp + 16'h0001;
        end
        if (q.ph == 2'h2)
        begin
          d.ph = 2'h0;
          if (!q.entry)
            d.xh = i_mem_rdata;
          else
          begin
            case (q.step)
              3'h0:    d.cc = i_mem_rdata | `CC_ONES;
              3'h1:    d.acc = i_mem_rdata;
              3'h2:    d.xl = i_mem_rdata;
              3'h3:    d.pc[15:8] = i_mem_rdata;
              default: d.pc[7:0] = i_mem_rdata;
            endcase
          end
          if (!q.entry || q.step == 3'h4)
          begin
            d.st = st_run;
            d.done = 1'b1;
            // a still-raised break traps again at once
            if (q.entry)
              d.in_brk = 1'b0;
          end
          else
            d.step = q.step + 3'h1;
        end
      end
      st_load:
      begin
        if (q.ph == 2'h0)
          d.mem.addr = {q.xh, q.xl};
        if (q.ph == 2'h2)
        begin
          d.ph = 2'h0;
          d.acc = i_mem_rdata;
          d.cc[`CC_V] = 1'b0;
          d.cc[`CC_N] = i_mem_rdata[7];
          d.cc[`CC_Z] = (i_mem_rdata == 8'h00);
          d.st = st_run;
          d.done = 1'b1;
        end
      end
      st_wait:
        entry_req = brk_pend | (|irq_pend);
      st_stop:
      begin
        if (|irq_pend)
        begin
          d.st = st_recover;
          d.cnt = i_short_recovery ? cnt_t'(`REC_SHORT - 1)
                                   : cnt_t'(LONG_RECOVERY - 1);
        end
      end
      st_recover:
      begin
        if (q.cnt != '0)
          d.cnt = q.cnt - cnt_t'(1);
        else if (brk_pend | (|irq_pend))
          entry_req = 1'b1;
        else
        begin
          d.st = st_run;
          d.stopped = 1'b0;
        end
      end
      default:
        d.st = st_run;
    endcase

    if (entry_req)
    begin
      d.st = st_push;
      d.entry = 1'b1;
      d.quiet = 1'b1;
      d.step = 3'h0;
      d.rdy = 1'b0;
      d.stopped = 1'b0;
      if (brk_pend)
      begin
        d.in_brk = 1'b1;
        d.vec = i_monitor ? `VEC_TRAP_MON : `VEC_TRAP;
      end
      else
        d.vec = `VEC_IRQ_TOP - 16'({win, 1'b0});
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // state register
  always_ff @(posedge i_clock)
  begin
    if (i_reset)
    begin
      q <= '0;
      q.st <= st_fetch;
      q.quiet <= 1'b1;
      q.vec <= `VEC_RESET;
      q.sp <= `RST_STACK;
      q.cc <= `CC_RESET;
    end
    else if (i_clock_en)
      q <= d;
  end

  assign o_ready = q.rdy;
  assign o_done = q.done;
  assign o_illegal = q.illegal;
  assign o_clock_stopped = q.stopped;
  assign o_in_break = q.in_brk;
  assign o_mem = q.mem;
  assign o_reg_rdata = q.rdata;
  assign o_accumulator = q.acc;
  assign o_index_pair = {q.xh, q.xl};
  assign o_stack_pointer = q.sp;
  assign o_program_counter = q.pc;
  assign o_condition_code_reg = q.cc;

  ////////////////////////////////////////////////////////////////////////
  // checks
  a_cc_ones: assert property (@(posedge i_clock) disable iff (i_reset)
    q.cc[6:5] == 2'b11)
    else $error("condition code ones lost");

  a_reset_state: assert property (@(posedge i_clock)
    $past(i_reset) && !i_reset |-> q.sp == `RST_STACK && q.cc[`CC_I]
      && q.st == st_fetch)
    else $error("reset state wrong");

  a_stack_reload: assert property (@(posedge i_clock)
    disable iff (i_reset)
    i_clock_en && take && i_op == stack_low_reload_op |=>
      q.sp[7:0] == `STACK_LOW_FF
      && ((q.sp ^ $past(q.sp)) & 16'hff00) == 16'h0000)
    else $error("stack reload wrong");

  a_push_addr: assert property (@(posedge i_clock) disable iff (i_reset)
    q.mem.write |-> q.mem.addr == q.sp + 16'h0001)
    else $error("push address not next free slot");

  a_mask_blocks: assert property (@(posedge i_clock)
    disable iff (i_reset)
    i_clock_en && q.st == st_run && q.cc[`CC_I] && !brk_pend
      && !(take && i_op == software_trap_op)
      |=> !(q.st == st_push && q.entry))
    else $error("masked request entered");

  a_entry_mask: assert property (@(posedge i_clock)
    disable iff (i_reset)
    i_clock_en && q.st == st_push && q.entry && q.step == 3'h4
      |=> q.cc[`CC_I] && q.st == st_fetch && q.ph == 2'h0)
    else $error("mask not set before vector");

  a_half_carry: assert property (@(posedge i_clock)
    disable iff (i_reset)
    i_clock_en && take && i_op == op_add |=> q.cc[`CC_H] == $past(hc_exp))
    else $error("half carry wrong");

  a_load_flags: assert property (@(posedge i_clock)
    disable iff (i_reset)
    i_clock_en && take && i_op == op_load |=> q.acc == $past(i_operand)
      && q.cc[`CC_Z] == (q.acc == 8'h00) && q.cc[`CC_N] == q.acc[7])
    else $error("load flags wrong");

  a_stop_illegal: assert property (@(posedge i_clock)
    disable iff (i_reset)
    i_clock_en && take && i_op == op_stop && !i_stop_enable
      |=> q.illegal && q.st == st_run && !q.stopped)
    else $error("disabled stop not illegal");

  a_short_recover: assert property (@(posedge i_clock)
    disable iff (i_reset)
    i_clock_en && q.st == st_stop && (|irq_pend) && i_short_recovery
      |=> q.st == st_recover && q.cnt == cnt_t'(31) && q.stopped)
    else $error("short recovery count wrong");

endmodule

// ==== tb/cpu_register_flag_core_tb_top.sv ====
`timescale 1ns/1ps
module cpu_register_flag_core_tb_top;
  import cpu_core_pkg::*;
  localparam int LREC = 40;
  logic        i_clock = 0, i_reset = 1, i_clock_en = 1, i_op_valid = 0;
  op_t         i_op = op_none;
  logic [7:0]  i_operand = 8'h00, i_mem_rdata;
  logic [3:0]  i_irq = 4'h0;
  logic        i_break = 0, i_break_en = 0, i_monitor = 0;
  logic        i_stop_enable = 0, i_short_recovery = 0;
  reg_req_t    i_reg = '0;
  logic        o_ready, o_done, o_illegal, o_clock_stopped, o_in_break;
  mem_req_t    o_mem;
  logic [7:0]  o_reg_rdata, o_accumulator, o_condition_code_reg, a, cc;
  logic [15:0] o_index_pair, o_stack_pointer, o_program_counter, ra, pcv;
  logic [23:0] wq [$];
  int          num_errors = 0, check_count = 0, ill = 0;
  always #12.5 i_clock = ~i_clock;
  cpu_register_flag_core #(.LONG_RECOVERY(LREC)) uut (.*);
  mem_model mem (.i_clock, .i_mem(o_mem), .o_rdata(i_mem_rdata));
  always @(posedge i_clock)
  begin
    if (o_mem.write)
      wq.push_back({o_mem.addr, o_mem.wdata});
    if (o_mem.read)
      ra <= o_mem.addr;
    if (o_illegal)
      ill++;
  end
  //////////////////////////////////////////////////////////////////////////
  task automatic end_of_test(bit hung = 0);
    if (hung)
      num_errors++;
    $display("checks %0d errors %0d", check_count, num_errors);
    if (num_errors == 0 && check_count > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  task automatic chk(string n, logic [23:0] e, logic [23:0] g);
    check_count++;
    if (g !== e)
    begin
      num_errors++;
      $display("unexpected %s: expected %h, seen %h", n, e, g);
    end
  endtask
  function automatic logic [15:0] vec(logic [15:0] x);
    return {x[7:0] ^ 8'h5a, x[7:0] ^ 8'h5b};
  endfunction
  task automatic tick(int n = 1);
    repeat (n) @(posedge i_clock);
  endtask
  task automatic guard(inout int n);
    if (++n > 9000)
      end_of_test(1);
  endtask
  task automatic wait_ready();
    int n = 0;
    while (o_ready !== 1'b1)
    begin
      tick();
      guard(n);
    end
  endtask
  task automatic op(op_t o, logic [7:0] v = 8'h00, bit wd = 1);
    int n = 0;
    wait_ready();
    i_op_valid <= 1'b1;
    i_op <= o;
    i_operand <= v;
    do
    begin
      tick();
      guard(n);
    end
    while (o_ready !== 1'b1);
    i_op_valid <= 1'b0;
    while (wd && o_done !== 1'b1)
    begin
      tick();
      guard(n);
    end
  endtask
  task automatic rw(logic [3:0] ad, logic [7:0] v);
    wait_ready();
    i_reg <= '{ad, v, 1'b1, 1'b0};
    tick();
    i_reg <= '0;
    tick();
  endtask
  task automatic rr(logic [3:0] ad, logic [7:0] e);
    i_reg <= '{ad, 8'h00, 1'b0, 1'b1};
    tick();
    i_reg <= '0;
    tick();
    chk("reg read", e, o_reg_rdata);
  endtask
  task automatic entry(logic [15:0] v);
    tick(3);
    wait_ready();
    chk("vector", vec(v), o_program_counter);
  endtask
  task automatic ret();
    i_irq <= 4'h0;
    i_break <= 1'b0;
    tick(4);
    op(interrupt_return_op);
    chk("ret mask", 0, o_condition_code_reg[3]);
    chk("in break", 0, o_in_break);
  endtask
  // reference alu: updates a and cc
  task automatic alu(op_t o, logic [7:0] d);
    int ci = (o == op_adc || o == op_sbc) ? int'(cc[0]) : 0;
    int r = (o inside {op_sub, op_sbc}) ? a - d - ci : a + d + ci;
    logic [7:0] y;
    y = o == op_and ? a & d : o == op_or ? a | d : o == op_xor ? a ^ d
      : o == op_load ? d : o == op_shl ? a << 1
      : o == op_shr ? a >> 1 : r[7:0];
    if (o inside {op_add, op_adc})
      cc[4] = (a[3:0] + d[3:0] + ci) > 15;
    cc[7] = o inside {op_add, op_adc} ? a[7] == d[7] && y[7] != a[7]
      : o inside {op_sub, op_sbc} ? a[7] != d[7] && y[7] != a[7]
      : o == op_shl ? y[7] ^ a[7] : o == op_shr ? a[0] : 1'b0;
    if (o inside {op_add, op_adc, op_sub, op_sbc})
      cc[0] = r[8];
    if (o == op_shl)
      cc[0] = a[7];
    if (o == op_shr)
      cc[0] = a[0];
    cc[2] = y[7];
    cc[1] = y == 8'h00;
    a = y;
  endtask
  //////////////////////////////////////////////////////////////////////////
  initial
  begin
    void'($urandom(11302));
    a = 8'h00;
    cc = 8'h68;
    tick(10);
    i_reset <= 1'b0;
    chk("sp", 16'h00ff, o_stack_pointer);
    chk("cc", 8'h68, o_condition_code_reg);
    wait_ready();
    chk("pc", vec(16'hfffe), o_program_counter);
    repeat (60)
    begin
      op_t o;
      logic [7:0] d;
      o = op_t'(int'(op_add) + $urandom_range(0, 9));
      d = 8'($urandom);
      alu(o, d);
      op(o, d);
      chk("acc", a, o_accumulator);
      chk("cc", cc, o_condition_code_reg);
    end
    // signed branch: plain, negative with overflow, and not taken
    alu(op_load, 8'h7f);
    op(op_load, 8'h7f);
    op(op_branch_ge, 8'hf0);
    alu(op_add, 8'h01);
    op(op_add, 8'h01);
    op(op_branch_ge, 8'h40);
    pcv = vec(16'hfffe) + 16'h0030;
    chk("branch", pcv, o_program_counter);
    alu(op_load, 8'h80);
    op(op_load, 8'h80);
    op(op_branch_ge, 8'h40);
    chk("branch", pcv, o_program_counter);
    rw(4'h7, 8'h00);
    rr(4'h7, 8'h68);
    rr(4'hf, 8'h00);
    rw(4'h3, 8'h12);
    rw(4'h4, 8'h40);
    op(stack_low_reload_op);
    chk("sp", 16'h12ff, o_stack_pointer);
    rw(4'h1, 8'h3c);
    rw(4'h2, 8'h81);
    chk("index", 16'h3c81, o_index_pair);
    op(op_load_indexed);
    chk("ix addr", 16'h3c81, ra);
    chk("acc", 8'h81 ^ 8'h5a, o_accumulator);
    a = 8'h81 ^ 8'h5a;
    wq.delete();
    i_irq <= 4'b0110;
    tick(8);
    chk("masked", 0, wq.size());
    op(mask_clear_op);
    entry(16'hfff8);
    chk("pushes", 5, wq.size());
    for (int i = 0; i < 4; i++)
      chk("push", {16'h12ff - 16'(i), i == 0 ? pcv[7:0] : i == 1
        ? pcv[15:8] : i == 2 ? 8'h81 : a}, wq[i]);
    chk("stk cc", {16'h12fb, 1'b0}, {wq[4][23:8], wq[4][3]});
    chk("mask", 1, o_condition_code_reg[3]);
    chk("sp", 16'h12fa, o_stack_pointer);
    ret();
    chk("pc", pcv, o_program_counter);
    chk("sp", 16'h12ff, o_stack_pointer);
    op(push_high_index_op);
    chk("sp", 16'h12fe, o_stack_pointer);
    rw(4'h1, 8'h00);
    op(pull_high_index_op);
    chk("index", 16'h3c81, o_index_pair);
    op(op_set_mask);
    op(op_wait, 8'h00, 0);
    tick(3);
    chk("stopped", 1, o_clock_stopped);
    chk("mask", 0, o_condition_code_reg[3]);
    wq.delete();
    i_irq <= 4'b0001;
    entry(16'hfffa);
    chk("stk mask", 0, wq[4][3]);
    ret();
    op(op_stop);
    tick();
    chk("illegal", 1, ill);
    i_stop_enable <= 1'b1;
    for (int k = 0; k < 2; k++)
    begin
      int n;
      n = 0;
      i_short_recovery <= k == 0;
      op(op_set_mask);
      op(op_stop, 8'h00, 0);
      tick(3);
      chk("mask", 0, o_condition_code_reg[3]);
      i_irq <= 4'b1000;
      while (o_clock_stopped === 1'b1)
      begin
        tick();
        guard(n);
      end
      chk("recovery", 1, (n - (k ? LREC : 32)) inside {[0:8]});
      entry(16'hfff4);
      ret();
    end
    i_break_en <= 1'b1;
    i_monitor <= 1'b1;
    i_break <= 1'b1;
    entry(16'hfefc);
    chk("in break", 1, o_in_break);
    ret();
    i_monitor <= 1'b0;
    op(software_trap_op);
    chk("trap pc", vec(16'hfffc), o_program_counter);
    ret();
    // reset while waiting: mask set again, vector refetched
    op(op_wait, 8'h00, 0);
    tick(3);
    i_reset <= 1'b1;
    tick(2);
    i_reset <= 1'b0;
    tick();
    chk("sp", 16'h00ff, o_stack_pointer);
    chk("reset mask", 1, o_condition_code_reg[3]);
    chk("stopped", 0, o_clock_stopped);
    wait_ready();
    chk("pc", vec(16'hfffe), o_program_counter);
    end_of_test();
  end
endmodule

// ==== tb/mem_model.sv ====
`timescale 1ns/1ps
module mem_model
  import cpu_core_pkg::*;
(
  input  wire logic                   i_clock, // core clock
  input  wire cpu_core_pkg::mem_req_t i_mem,   // core request
  output logic [7:0]                  o_rdata  // read data
);
  logic [7:0] mem [0:65535];
  initial
  begin
    for (int a = 0; a < 65536; a++)
      mem[a] = 8'(a) ^ 8'h5a;
  end
  // data valid one cycle after read only, toggles otherwise
  always @(posedge i_clock)
  begin
    o_rdata <= i_mem.read ? mem[i_mem.addr] : ~o_rdata;
    if (i_mem.write)
      mem[i_mem.addr] <= i_mem.wdata;
  end
endmodule
